// ### logic/spi_flags_clocking_unit.v
// Serial port unit: flags, clock format, master divider, slave shifter
`timescale 1ns/1ps
`default_nettype none
`include "spi_unit_defs.vh"

module spi_flags_clocking_unit (
  input wire clk, // Core clock
  input wire reset, // Synchronous reset, active high
  input wire [7:0] sfr_addr, // Register address
  input wire sfr_wr, // Register write strobe
  input wire sfr_rd, // Register read strobe
  input wire [7:0] sfr_wdata, // Register write data
  output reg [7:0] sfr_rdata, // Register read data, one cycle after strobe
  output reg irq_req, // Interrupt request, any flag set
  input wire sck_in, // SCK pin level
  output reg sck_out, // SCK driven level
  output reg sck_oe, // SCK drive enable
  input wire mosi_in, // MOSI pin level
  output reg mosi_out, // MOSI driven level
  output reg mosi_oe, // MOSI drive enable
  input wire miso_in, // MISO pin level
  output reg miso_out, // MISO driven level
  output reg miso_oe, // MISO drive enable
  input wire nss_in, // Select pin level
  output reg nss_out, // Select driven level
  output reg nss_oe // Select drive enable
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg sck_prev_r;
  reg nss_prev_r;
  wire sck_s = sync2_r[0];
  wire mosi_s = sync2_r[1];
  wire miso_s = sync2_r[2];
  wire nss_s = sync2_r[3];

  // Two flops on every pin input
  always @(posedge clk) begin
    sync1_r <= {nss_in, miso_in, mosi_in, sck_in};
    sync2_r <= sync1_r;
    sck_prev_r <= sck_s;
    nss_prev_r <= nss_s;
  end

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  reg master_r, cpha_r, cpol_r;
  reg done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r, smhi_r, smlo_r, en_r;
  reg [7:0] rate_r;
  reg [7:0] txbuf_r;
  reg txfull_r;
  reg [7:0] sh_r;
  reg sh_empty_r;
  reg [7:0] rxsh_r;
  reg [7:0] rxbuf_r;
  reg rxfull_r;
  reg [3:0] bitcnt_r;
  reg busy_r;
  reg [7:0] div_r;
  reg half_r;
  reg [1:0] reload_r;

  // Address decode and mode terms
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire wr_data = sfr_wr && hit(sfr_addr, `ADDR_DATA);
  wire wr_ctl = sfr_wr && hit(sfr_addr, `ADDR_CONTROL);
  wire wr_cfg = sfr_wr && hit(sfr_addr, `ADDR_CONFIG);
  wire rd_data = sfr_rd && hit(sfr_addr, `ADDR_DATA);
  wire is_master = en_r && master_r;
  wire is_slave = en_r && !master_r;
  wire four_wire_in = !smhi_r && smlo_r;
  wire selected = four_wire_in ? !nss_s : 1'b1;
  wire nss_fall = nss_prev_r && !nss_s;

  // Slave SCK edges, only while selected
  wire sck_edge = is_slave && selected && (sck_s != sck_prev_r);
  wire lead_edge = sck_edge && (sck_s != cpol_r);
  wire samp_edge = cpha_r ? (sck_edge && !lead_edge) : lead_edge;
  wire shift_edge = cpha_r ? lead_edge : (sck_edge && !lead_edge);
  wire slv_done = samp_edge && (bitcnt_r == 4'h7);
  wire [7:0] slv_byte = {rxsh_r[6:0], mosi_s};

  // Master timing terms
  wire div_end = (div_r == rate_r);
  wire bit_end = busy_r && is_master && div_end && half_r;
  wire mst_done = bit_end && (bitcnt_r == 4'h7);
  wire mode_fault = is_master && four_wire_in && !nss_s;

  // Shifter may take the buffer now
  wire mst_start = is_master && !busy_r && txfull_r;
  wire slv_idle_load = is_slave && sh_empty_r && txfull_r && (bitcnt_r == 4'h0) &&
                       (reload_r == 2'h0);
  // Buffer moves into the shifter this cycle
  wire tx_taken = mst_start || slv_idle_load || (reload_r == 2'h1) ||
                  (slv_done && !cpha_r && txfull_r);
  // Phase 1 reload delay, cut to the counter width on purpose
  localparam [31:0] RELOAD_FULL = `RELOAD_DELAY;

  // ------------------------------------------------------------
  // Configuration and rate registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      master_r <= 1'b0;
      cpha_r <= 1'b0;
      cpol_r <= 1'b0;
      rate_r <= `RST_RATE;
    end else begin
      if (wr_cfg) begin
        master_r <= sfr_wdata[`CFG_MSTR];
        cpha_r <= sfr_wdata[`CFG_CPHA];
        cpol_r <= sfr_wdata[`CFG_CPOL];
      end
      if (mode_fault) begin
        master_r <= 1'b0;
      end
      if (sfr_wr && hit(sfr_addr, `ADDR_RATE)) begin
        rate_r <= sfr_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register and flags; a set beats a clear
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      ovrn_r <= 1'b0;
      smhi_r <= 1'b0;
      smlo_r <= 1'b1;
      en_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        done_r <= sfr_wdata[`CTL_DONE] | mst_done | slv_done;
        write_collision_flag_r <= sfr_wdata[`CTL_WRITE_COLLISION_FLAG] | (wr_data & txfull_r);
        mode_fault_flag_r <= sfr_wdata[`CTL_MODE_FAULT_FLAG] | mode_fault;
        ovrn_r <= sfr_wdata[`CTL_OVRN] | (slv_done & rxfull_r);
        smhi_r <= sfr_wdata[`CTL_SMHI];
        smlo_r <= sfr_wdata[`CTL_SMLO];
        en_r <= sfr_wdata[`CTL_EN] & !mode_fault;
      end else begin
        done_r <= done_r | mst_done | slv_done;
        write_collision_flag_r <= write_collision_flag_r | (wr_data & txfull_r);
        mode_fault_flag_r <= mode_fault_flag_r | mode_fault;
        ovrn_r <= ovrn_r | (slv_done & rxfull_r);
        if (mode_fault) begin
          en_r <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      txbuf_r <= 8'h00;
      txfull_r <= 1'b0;
    end else if (wr_data && !txfull_r) begin
      txbuf_r <= sfr_wdata;
      txfull_r <= 1'b1;
    end else if (wr_data) begin
      txfull_r <= !tx_taken;
    end else if (tx_taken) begin
      txfull_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Receive buffer; cleared by a data read
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      rxbuf_r <= 8'h00;
      rxfull_r <= 1'b0;
    end else if (slv_done && !rxfull_r) begin
      rxbuf_r <= slv_byte;
      rxfull_r <= 1'b1;
    end else if (mst_done) begin
      rxbuf_r <= {sh_r[6:0], miso_s};
      rxfull_r <= 1'b1;
    end else if (rd_data && !slv_done) begin
      rxfull_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Master clock divider: one half period per rate+1 clocks
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset || !busy_r || !is_master || div_end) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Shifter, bit counter and busy
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset || !en_r || mode_fault) begin
      sh_r <= 8'h00;
      sh_empty_r <= 1'b1;
      rxsh_r <= 8'h00;
      bitcnt_r <= 4'h0;
      busy_r <= 1'b0;
      half_r <= 1'b0;
      reload_r <= 2'h0;
    end else if (is_master) begin
      if (mst_start) begin
        sh_r <= txbuf_r;
        sh_empty_r <= 1'b0;
        busy_r <= 1'b1;
        bitcnt_r <= 4'h0;
        half_r <= 1'b0;
      end else if (busy_r && div_end) begin
        half_r <= !half_r;
        if (half_r) begin
          sh_r <= {sh_r[6:0], miso_s};
          bitcnt_r <= bitcnt_r + 4'h1;
          if (mst_done) begin
            busy_r <= 1'b0;
            sh_empty_r <= 1'b1;
            bitcnt_r <= 4'h0;
          end
        end
      end
    end else begin
      busy_r <= (bitcnt_r != 4'h0);
      if (four_wire_in && nss_fall) begin
        bitcnt_r <= 4'h0;
      end else if (samp_edge) begin
        rxsh_r <= slv_byte;
        bitcnt_r <= slv_done ? 4'h0 : bitcnt_r + 4'h1;
      end
      if (slv_done) begin
        sh_empty_r <= 1'b1;
        if (cpha_r && txfull_r) begin
          reload_r <= RELOAD_FULL[1:0];
        end else if (txfull_r) begin
          sh_r <= txbuf_r;
          sh_empty_r <= 1'b0;
        end
      end else if (slv_idle_load) begin
        sh_r <= txbuf_r;
        sh_empty_r <= 1'b0;
      end else if (reload_r != 2'h0) begin
        reload_r <= reload_r - 2'h1;
        if (reload_r == 2'h1) begin
          sh_r <= txbuf_r;
          sh_empty_r <= 1'b0;
        end
      end else if (shift_edge && bitcnt_r != 4'h0) begin
        sh_r <= {sh_r[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers, all registered
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      nss_out <= 1'b1;
      nss_oe <= 1'b0;
    end else begin
      // Idle at polarity; active half depends on phase
      sck_out <= (busy_r && is_master) ? (cpol_r ^ (half_r ^ cpha_r)) : cpol_r;
      sck_oe <= is_master;
      mosi_out <= sh_r[7];
      mosi_oe <= is_master;
      miso_out <= sh_r[7];
      miso_oe <= is_slave && selected;
      nss_out <= smlo_r;
      nss_oe <= en_r && smhi_r;
    end
  end

  // ------------------------------------------------------------
  // Read data and interrupt request
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
      irq_req <= 1'b0;
    end else begin
      irq_req <= done_r | write_collision_flag_r | mode_fault_flag_r | ovrn_r;
      if (sfr_rd) begin
        case (sfr_addr)
          `ADDR_CONFIG: sfr_rdata <= {busy_r, master_r, cpha_r, cpol_r,
                                      is_slave && selected, nss_s, sh_empty_r,
                                      master_r | !rxfull_r};
          `ADDR_CONTROL: sfr_rdata <= {done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r,
                                       smhi_r, smlo_r, !txfull_r, en_r};
          `ADDR_RATE: sfr_rdata <= rate_r;
          `ADDR_DATA: sfr_rdata <= rxbuf_r;
          default: sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // spi_flags_clocking_unit
`default_nettype wire

// ### logic/spi_unit_defs.vh
// Register map, field positions, reset values and timing counts of the serial port unit
`ifndef SPI_UNIT_DEFS_VH
`define SPI_UNIT_DEFS_VH
// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define ADDR_CONFIG 8'ha1
`define ADDR_RATE 8'ha2
`define ADDR_DATA 8'ha3
`define ADDR_CONTROL 8'hf8
// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTL_DONE 7
`define CTL_WRITE_COLLISION_FLAG 6
`define CTL_MODE_FAULT_FLAG 5
`define CTL_OVRN 4
`define CTL_SMHI 3
`define CTL_SMLO 2
`define CTL_TXMT 1
`define CTL_EN 0
// ------------------------------------------------------------
// Config register fields
// ------------------------------------------------------------
`define CFG_BUSY 7
`define CFG_MSTR 6
`define CFG_CPHA 5
`define CFG_CPOL 4
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_CONFIG 8'h07
`define RST_CONTROL 8'h06
`define RST_RATE 8'h00
// ------------------------------------------------------------
// Timing: core clock period in ns, other counts in system clock periods
// ------------------------------------------------------------
`define CORE_PERIOD_NS 50
`define LAST_EDGE_MIN_T 6
`define SYNC_LATENCY 3
`define RELOAD_DELAY ((`LAST_EDGE_MIN_T) - (`SYNC_LATENCY))
`endif

// ### testbench/spi_slave_model.sv
// Behavioural serial slave facing the master side of the port
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input wire logic sck, // Serial clock from the master
  input wire logic mosi, // Data from the master
  input wire logic active, // Frame in progress
  input wire logic [7:0] tx_byte, // Byte returned each frame
  output logic miso, // Data to the master
  output logic [7:0] rx_byte // Bits taken in, MSB first
);
  logic [3:0] cnt = 4'h0;
  logic bit_in = 1'b0;
  // Same phase and polarity as the master: latch on rise, shift on fall
  always @(posedge active) cnt = 4'h0;
  always @(posedge sck) bit_in = mosi;
  always @(negedge sck) begin
    if (active) begin
      rx_byte = {rx_byte[6:0], bit_in};
      cnt = cnt + 4'h1;
    end
  end
  // Outside a frame the line shows the inverse of the last bit
  assign miso = active ? tx_byte[3'd7 - cnt[2:0]] : ~tx_byte[0];
endmodule // spi_slave_model
`default_nettype wire

// ### testbench/spi_unit_checker.sv
// Port-level assertions for the serial port unit
`timescale 1ns/1ps
`default_nettype none
module spi_unit_checker (
  input wire logic clk, // Core clock
  input wire logic reset, // Sync reset
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic irq_req, // Flag request
  input wire logic sck_out, // SCK level
  input wire logic sck_oe, // SCK enable
  input wire logic mosi_oe, // MOSI enable
  input wire logic miso_oe, // MISO enable
  input wire logic nss_in, // Select pin
  input wire logic nss_out, // Select level
  input wire logic nss_oe // Select enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] rate_r;
  logic [1:0] mode_r;
  logic lvl_r;
  logic [8:0] gap_r;
  // Shadows of written fields and cycles since the last SCK change
  always @(posedge clk) begin
    if (reset) begin
      rate_r <= 8'h00;
      mode_r <= 2'b01;
      lvl_r <= 1'b1;
      gap_r <= 9'h1ff;
    end else begin
      if (sfr_wr && sfr_addr == 8'ha2) rate_r <= sfr_wdata;
      if (sfr_wr && sfr_addr == 8'hf8) mode_r <= sfr_wdata[3:2];
      if (sfr_wr && sfr_addr == 8'hf8) lvl_r <= sfr_wdata[2];
      gap_r <= $changed(sck_out) ? 9'h001 : (gap_r == 9'h1ff ? gap_r : gap_r + 9'h001);
    end
  end
  chk_reset_idle: assert property ($fell(reset) |-> !sck_oe && !mosi_oe && !nss_oe && !irq_req)
    else $error("outputs active after reset");
  chk_flag_hold: assert property (irq_req && !sfr_wr && !$past(sfr_wr) |=> irq_req)
    else $error("flag request dropped without a write");
  chk_master_drive: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master drive enables inconsistent");
  chk_sck_spacing: assert property (sck_oe && $past(sck_oe) && $changed(sck_out)
    |-> gap_r >= {1'b0, rate_r} + 9'h001)
    else $error("SCK half period too short");
  chk_fault_release: assert property (sck_oe && mode_r == 2'b01 && !nss_in
    |-> ##[1:6] !sck_oe)
    else $error("master kept bus after select low");
  chk_select_drive: assert property (sfr_wr && sfr_addr == 8'hf8 && sfr_wdata[3] && sfr_wdata[0]
    |-> ##[1:3] (nss_oe && nss_out == lvl_r))
    else $error("select output wrong");
  chk_start_clock: assert property (sck_oe && sfr_wr && sfr_addr == 8'ha3
    |-> ##[1:600] $changed(sck_out))
    else $error("no clock after data write");
  chk_miso_release: assert property (miso_oe && $rose(nss_in) |-> ##[1:4] !miso_oe)
    else $error("MISO not released");
endmodule // spi_unit_checker
bind spi_flags_clocking_unit spi_unit_checker chk_u (.clk(clk), .reset(reset),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .irq_req(irq_req),
  .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe));
`default_nettype wire

// ### testbench/spi_flags_clocking_unit_tb.sv
// Self-checking bench for the serial port unit in master and slave modes
`timescale 1ns/1ps
`default_nettype none
module spi_flags_clocking_unit_tb;
  logic clk, reset, sfr_wr, sfr_rd, nss_in, frame, irq_req, sck_out, sck_oe;
  logic mosi_out, mosi_oe, miso_out, miso_oe, nss_out, nss_oe, miso_w;
  logic ext_sck, ext_mosi;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_byte, d;
  int err_count, n_tests, i, w, el, idle;
  // Rows: write flag, address, write data or expected read
  logic [16:0] rows [0:9] = '{17'h0a107, 17'h0f806, 17'h0a200, 17'h05500, 17'h1a201,
    17'h0a201, 17'h1a140, 17'h0a147, 17'h1f801, 17'h0f803};
  spi_flags_clocking_unit dut_u (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .irq_req(irq_req), .sck_in(sck_oe ? sck_out : ext_sck), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_oe ? mosi_out : ext_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .nss_in(nss_in),
    .nss_out(nss_out), .nss_oe(nss_oe));
  spi_slave_model peer_u (.sck(sck_oe & sck_out), .mosi(mosi_out), .active(frame),
    .tx_byte(8'h3c), .miso(miso_w), .rx_byte(rx_byte));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = v;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    v = sfr_rdata;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // External master: one byte, phase 0, ten clocks per bit, MISO taken before each rise
  task sbyte(input logic [7:0] m, output logic [7:0] got);
    for (int b = 7; b >= 0; b--) begin
      ext_mosi = m[b];
      repeat (5) @(negedge clk);
      got[b] = miso_out;
      ext_sck = 1'b1;
      repeat (5) @(negedge clk);
      ext_sck = 1'b0;
    end
    repeat (5) @(negedge clk);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    nss_in = 1'b1;
    frame = 1'b0;
    ext_sck = 1'b0;
    ext_mosi = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    for (i = 0; i < 10; i++) begin
      if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
      else rd(rows[i][15:8], d);
      if (!rows[i][16]) chk("table", d, rows[i][7:0]);
    end
    // One master byte at rate 1
    frame = 1'b1;
    wr(8'ha3, 8'ha5);
    el = $time;
    rd(8'hf8, d);
    chk("tx empty", d, 8'h03);
    rd(8'ha1, d);
    chk("busy", {7'h00, d[7]}, 8'h01);
    for (w = 0; w < 100 && irq_req !== 1'b1; w++) @(negedge clk);
    el = ($time - el) / 50;
    chk("duration", {7'h00, el >= 32 && el <= 38}, 8'h01);
    frame = 1'b0;
    chk("mosi byte", rx_byte, 8'ha5);
    rd(8'ha3, d);
    chk("miso byte", d, 8'h3c);
    rd(8'hf8, d);
    chk("done flag", d, 8'h83);
    repeat (20) @(negedge clk);
    chk("irq held", {7'h00, irq_req}, 8'h01);
    wr(8'hf8, 8'h01);
    repeat (3) @(negedge clk);
    chk("irq cleared", {7'h00, irq_req}, 8'h00);
    // Collision: third write while the buffer is still full
    frame = 1'b1;
    wr(8'ha3, 8'h11);
    wr(8'ha3, 8'h22);
    rd(8'hf8, d);
    chk("tx full", d, 8'h01);
    wr(8'ha3, 8'h33);
    rd(8'hf8, d);
    chk("collision", d, 8'h41);
    idle = 0;
    for (w = 0; w < 100 && idle < 2; w++) begin
      rd(8'ha1, d);
      idle = d[7] ? 0 : idle + 1;
    end
    chk("kept byte", rx_byte, 8'h22);
    frame = 1'b0;
    // Mode fault in multi-master mode
    wr(8'hf8, 8'h05);
    nss_in = 1'b0;
    repeat (8) @(negedge clk);
    rd(8'hf8, d);
    chk("mode fault", d, 8'h26);
    rd(8'ha1, d);
    chk("master off", d & 8'hc0, 8'h00);
    nss_in = 1'b1;
    // Idle clock level and driven select
    wr(8'hf8, 8'h00);
    wr(8'ha1, 8'h50);
    wr(8'hf8, 8'h01);
    repeat (4) @(negedge clk);
    chk("sck idle", {7'h00, sck_out}, 8'h01);
    wr(8'hf8, 8'h0d);
    repeat (3) @(negedge clk);
    chk("select high", {6'h00, nss_oe, nss_out}, 8'h03);
    wr(8'hf8, 8'h09);
    repeat (3) @(negedge clk);
    chk("select low", {6'h00, nss_oe, nss_out}, 8'h02);
    // Four-wire slave: two bytes, second one overruns
    rd(8'ha3, d);
    wr(8'hf8, 8'h00);
    wr(8'ha1, 8'h00);
    wr(8'hf8, 8'h05);
    wr(8'ha3, 8'hc3);
    nss_in = 1'b0;
    repeat (4) @(negedge clk);
    chk("miso drive", {6'h00, miso_oe, miso_out}, 8'h03);
    sbyte(8'h96, d);
    chk("miso bits", d, 8'hc3);
    sbyte(8'h5a, d);
    rd(8'ha3, d);
    chk("slave rx", d, 8'h96);
    rd(8'hf8, d);
    chk("overrun", d, 8'h97);
    nss_in = 1'b1;
    repeat (5) @(negedge clk);
    chk("miso off", {7'h00, miso_oe}, 8'h00);
    // Reset in mid-run
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd(8'hf8, d);
    chk("control reset", d, 8'h06);
    chk("drives off", {6'h00, sck_oe, nss_oe}, 8'h00);
    final_report;
  end
endmodule // spi_flags_clocking_unit_tb
`default_nettype wire
